// *** cbs_top.sv ***
// Brake sequencer of a crane motion drive with an APB register file.
// What this block does
// - Close brake when speed below set percentage.
// - Close brake after delay with zero commands.
// - Open acknowledge timeout raises fault, stops motion.
// - Closing supervision failure is a dangerous fault.
// - Hold zero speed for hold time.
// - Hold time applies to travel and hoist.
// - Lift and forcing outputs rise together.
// - Forcing output drops after forcing time.
// - Acknowledge drops forcing output early.
// - Without forcing, output is off-delayed auxiliary.
// - Source setting one keeps full forcing time.
// - Source setting zero allows early forcing end.
// - Integral disabled near zero speed by default.
// - Settings 10 and 11 keep integral active.
// - Torque output: full scale is 400 percent.
// - Speed output: full scale is 200 percent.
// - Cabin inputs are references, 100 percent synchronous.
// - Brake open 500 ms after close: latched fault.
// - Acknowledge timeout set in milliseconds, default 1000.
`timescale 1ns/10ps
module cbs_top #(
    parameter int TICK_CYC = cbs_pkg::TICK_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               ce,
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               dir_a,
    input  wire logic               dir_b,
    input  wire logic               brake_ack,
    input  wire logic signed [15:0] speed_ref,
    input  wire logic signed [15:0] speed_act,
    input  wire logic signed [15:0] torque_act,
    input  wire logic signed [15:0] cabin_ain_one_raw,
    input  wire logic signed [15:0] cabin_ain_two_raw,
    output logic signed [15:0]      cabin_speed_ref_one,
    output logic signed [15:0]      cabin_speed_ref_two,
    output logic signed [15:0]      cabin_torque_out,
    output logic signed [15:0]      cabin_speed_out,
    output logic                    brake_lift,
    output logic                    dc_forcing,
    output logic                    hold_zero,
    output logic                    drive_enable,
    output logic                    integral_enable,
    output logic                    open_fault,
    output logic                    dangerous_fault,
    output logic                    fault_relay_open
);
    import cbs_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] next_sync1;
    logic       s_dir_a;
    logic       s_dir_b;
    logic       s_ack;

    always_comb begin
        next_sync1 = {brake_ack, dir_b, dir_a};
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else if (ce) begin
            sync1 <= next_sync1;
            sync2 <= sync1;
        end
    end

    // Only the second stage is read, so no logic ever sees a metastable first stage.
    assign s_dir_a = sync2[0];
    assign s_dir_b = sync2[1];
    assign s_ack   = sync2[2];

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    cbs_cfg_s    cfg;
    cbs_cfg_s    next_cfg;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic        rd_valid;
    logic        next_rd_valid;
    logic        wr_en;
    logic        fclr;
    logic        mapped;
    cbs_state_e  state;

    assign wr_en  = psel & penable & pwrite & pready;
    // The access phase answers at once; rd_valid remembers that a setup cycle was seen.
    assign pready = ce & penable & rd_valid;

    always_comb begin
        next_cfg    = cfg;
        next_prdata = 32'h0;
        mapped      = 1'b1;
        fclr        = 1'b0;
        unique case (paddr)
            A_CTRL:   next_prdata = {29'h0, cfg.sup_en, cfg.dc_used, cfg.ack_req};
            A_ACKSRC: next_prdata = {24'h0, cfg.ack_src};
            A_SPDPCT: next_prdata = {28'h0, cfg.speed_pct};
            A_ACKTO:  next_prdata = {16'h0, cfg.ack_to};
            A_HOLD:   next_prdata = {16'h0, cfg.hold};
            A_FORCE:  next_prdata = {16'h0, cfg.force_t};
            A_REFDLY: next_prdata = {16'h0, cfg.refdly};
            A_STATUS: next_prdata = {22'h0, state, s_ack, integral_enable, dangerous_fault,
                                     open_fault, hold_zero, dc_forcing, brake_lift};
            A_FCLR:   next_prdata = 32'h0;
            default:  mapped = 1'b0;
        endcase
        if (wr_en) begin
            unique case (paddr)
                A_CTRL: begin
                    next_cfg.ack_req = pwdata[CTRL_ACKREQ];
                    next_cfg.dc_used = pwdata[CTRL_DCUSE];
                    next_cfg.sup_en  = pwdata[CTRL_SUPEN];
                end
                A_ACKSRC: next_cfg.ack_src   = pwdata[7:0];
                A_SPDPCT: next_cfg.speed_pct = pwdata[3:0];
                A_ACKTO:  next_cfg.ack_to    = pwdata[15:0];
                A_HOLD:   next_cfg.hold      = pwdata[15:0];
                A_FORCE:  next_cfg.force_t   = pwdata[15:0];
                A_REFDLY: next_cfg.refdly    = pwdata[15:0];
                A_FCLR:   fclr               = pwdata[FCLR_OPEN];
                default:  fclr               = 1'b0;
            endcase
        end
        next_pslverr  = ~mapped;
        next_rd_valid = psel;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg      <= '{ack_req: 1'b1, dc_used: 1'b1, sup_en: 1'b0, ack_src: ACKSRC_RST,
                          speed_pct: SPDPCT_RST, ack_to: ACKTO_RST, hold: HOLD_RST,
                          force_t: FORCE_RST, refdly: REFDLY_RST};
            prdata   <= 32'h0;
            pslverr  <= 1'b0;
            rd_valid <= 1'b0;
        end else if (ce) begin
            cfg      <= next_cfg;
            prdata   <= next_prdata;
            pslverr  <= next_pslverr;
            rd_valid <= next_rd_valid;
        end
    end

    // ------------------------------------------------------------
    // Brake sequencer and millisecond timers
    // ------------------------------------------------------------
    cbs_state_e  next_state;
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic        tick;
    logic [15:0] tmr      [4];
    logic [15:0] next_tmr [4];
    logic [3:0]  tmr_clr;
    logic [3:0]  tmr_run;
    logic        next_dc;
    logic        next_open_fault;
    logic        next_dang;
    logic        stop_cmd;
    logic        below;
    logic        ack_to_hit;
    logic        early_end;
    logic [15:0] abs_act;
    logic [15:0] thresh;

    // Timer 0 counts time in the current state, 1 the zero-command delay,
    // 2 the auxiliary off-delay and 3 the time since the close order.
    assign tick     = (tick_cnt == 32'(TICK_CYC - 1));
    assign stop_cmd = ~s_dir_a & ~s_dir_b;
    assign abs_act  = speed_act[15] ? 16'(-speed_act) : speed_act;
    // Widen before multiplying, or the threshold would wrap inside four bits.
    assign thresh   = 16'(cfg.speed_pct) * 16'h000A;
    assign below    = abs_act < thresh;
    assign ack_to_hit = cfg.ack_req & ~s_ack & (tmr[0] >= cfg.ack_to);
    // Source settings 1 and 11 take the contactor as acknowledgement, so forcing runs its full time.
    assign early_end  = cfg.ack_req & s_ack & (cfg.ack_src != 8'h01) & (cfg.ack_src != 8'h0B);

    always_comb begin
        next_state      = state;
        // A timeout in the same cycle as a clear wins, so no fault is lost.
        next_open_fault = (open_fault & ~fclr) | (state == ST_OPEN && ack_to_hit);
        unique case (state)
            ST_CLOSED: begin
                if (!stop_cmd && !open_fault && !dangerous_fault)
                    next_state = ST_OPEN;
            end
            ST_OPEN: begin
                if (ack_to_hit)
                    next_state = ST_CLOSED;
                else if (stop_cmd && below)
                    next_state = ST_HOLD;
                else if (stop_cmd && speed_ref == 16'sh0 && tmr[1] >= cfg.refdly)
                    next_state = ST_HOLD;
            end
            ST_HOLD: begin
                if (tmr[0] >= cfg.hold)
                    next_state = ST_CLOSED;
            end
            default: next_state = ST_CLOSED;
        endcase

        next_tick_cnt = (tick || next_state != state) ? 32'h0 : tick_cnt + 32'h1;
        // Timers 2 and 3 both measure time since the close order, so both rest while open.
        tmr_clr[0] = (next_state != state);
        tmr_clr[1] = !stop_cmd || speed_ref != 16'sh0;
        tmr_clr[2] = (state == ST_OPEN);
        tmr_clr[3] = (state == ST_OPEN);
        tmr_run = {4{tick}};
        for (int i = 0; i < 4; i++) begin
            if (tmr_clr[i])
                next_tmr[i] = 16'h0;
            else if (tmr_run[i] && tmr[i] != 16'hFFFF)
                next_tmr[i] = tmr[i] + 16'h1;
            else
                next_tmr[i] = tmr[i];
        end

        if (cfg.dc_used)
            next_dc = (next_state == ST_OPEN) &
                      ((state != ST_OPEN) | (dc_forcing & (tmr[0] < cfg.force_t) & ~early_end));
        else
            next_dc = (next_state == ST_OPEN) | (dc_forcing & (tmr[2] < cfg.force_t));

        // The latch is only released by reset, which stands for cycling control power.
        next_dang = dangerous_fault |
                    (cfg.sup_en & s_ack & state != ST_OPEN & tmr[3] >= CLOSE_SUP_MS);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state           <= ST_CLOSED;
            tick_cnt        <= 32'h0;
            tmr             <= '{default: 16'h0};
            dc_forcing      <= 1'b0;
            open_fault      <= 1'b0;
            dangerous_fault <= 1'b0;
        end else if (ce) begin
            state           <= next_state;
            tick_cnt        <= next_tick_cnt;
            tmr             <= next_tmr;
            dc_forcing      <= next_dc;
            open_fault      <= next_open_fault;
            dangerous_fault <= next_dang;
        end
    end

    assign brake_lift       = (state == ST_OPEN);
    assign hold_zero        = (state == ST_HOLD);
    assign drive_enable     = (state != ST_CLOSED) & ~open_fault & ~dangerous_fault;
    assign fault_relay_open = dangerous_fault;

    // ------------------------------------------------------------
    // Analog scaling and speed regulator integral enable
    // ------------------------------------------------------------
    logic signed [15:0] next_ref_one;
    logic signed [15:0] next_ref_two;
    logic signed [15:0] next_trq;
    logic signed [15:0] next_spd;
    logic               next_int;

    always_comb begin
        // Values beyond the output range saturate instead of wrapping.
        next_ref_one = cbs_scale(cabin_ain_one_raw, REF_FS, DAC_FS);
        next_ref_two = cbs_scale(cabin_ain_two_raw, REF_FS, DAC_FS);
        next_trq     = cbs_scale(torque_act, DAC_FS, TORQUE_FS);
        next_spd     = cbs_scale(speed_act, DAC_FS, SPEED_FS);
        next_int     = (cfg.ack_src >= ACKSRC_TENS) | (abs_act > NEAR_ZERO);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cabin_speed_ref_one <= 16'sh0;
            cabin_speed_ref_two <= 16'sh0;
            cabin_torque_out    <= 16'sh0;
            cabin_speed_out     <= 16'sh0;
            integral_enable     <= 1'b0;
        end else if (ce) begin
            cabin_speed_ref_one <= next_ref_one;
            cabin_speed_ref_two <= next_ref_two;
            cabin_torque_out    <= next_trq;
            cabin_speed_out     <= next_spd;
            integral_enable     <= next_int;
        end
    end

endmodule

// *** cbs_pkg.sv ***
// Package with constants, types and helpers of the crane brake sequencer.
package cbs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ       = 125_000_000;
    localparam int          TICK_MS      = 1;
    localparam int          TICK_CYCLES  = TICK_MS * (CLK_HZ / 1000);
    localparam logic [15:0] CLOSE_SUP_MS = 16'h01F4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_ACKSRC = 8'h04;
    localparam logic [7:0] A_SPDPCT = 8'h08;
    localparam logic [7:0] A_ACKTO  = 8'h0C;
    localparam logic [7:0] A_HOLD   = 8'h10;
    localparam logic [7:0] A_FORCE  = 8'h14;
    localparam logic [7:0] A_REFDLY = 8'h18;
    localparam logic [7:0] A_STATUS = 8'h1C;
    localparam logic [7:0] A_FCLR   = 8'h20;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_ACKREQ  = 0;
    localparam int          CTRL_DCUSE   = 1;
    localparam int          CTRL_SUPEN   = 2;
    localparam int          FCLR_OPEN    = 0;
    localparam logic [7:0]  ACKSRC_RST   = 8'h00;
    localparam logic [7:0]  ACKSRC_TENS  = 8'h0A;
    localparam logic [3:0]  SPDPCT_RST   = 4'h2;
    localparam logic [15:0] ACKTO_RST    = 16'h03E8;
    localparam logic [15:0] HOLD_RST     = 16'h0064;
    localparam logic [15:0] FORCE_RST    = 16'h05DC;
    localparam logic [15:0] REFDLY_RST   = 16'h03E8;

    // ------------------------------------------------------------
    // Analog scaling, values in 0.1 percent units except DAC_FS, which is in converter counts
    // ------------------------------------------------------------
    localparam logic [15:0] NEAR_ZERO    = 16'h0005;
    localparam int          TORQUE_FS    = 4000;
    localparam int          SPEED_FS     = 2000;
    localparam int          REF_FS       = 1000;
    localparam int          DAC_FS       = 32767;

    typedef enum logic [2:0] {
        ST_CLOSED = 3'b001,
        ST_OPEN   = 3'b010,
        ST_HOLD   = 3'b100
    } cbs_state_e;

    typedef struct packed {
        logic        ack_req;
        logic        dc_used;
        logic        sup_en;
        logic [7:0]  ack_src;
        logic [3:0]  speed_pct;
        logic [15:0] ack_to;
        logic [15:0] hold;
        logic [15:0] force_t;
        logic [15:0] refdly;
    } cbs_cfg_s;

    // Scales x by num/den and saturates to a signed 16-bit value.
    function automatic logic signed [15:0] cbs_scale(input logic signed [15:0] x,
                                                     input int num, input int den);
        logic signed [47:0] p;
        p = (48'(x) * 48'(num)) / 48'(den);
        if (p > 48'sd32767)
            return 16'sh7FFF;
        else if (p < -48'sd32767)
            return -16'sh7FFF;
        return p[15:0];
    endfunction

endpackage

// *** cbs_top_properties.sv ***
// Concurrent checks on the ports of the brake sequencer.
`timescale 1ns/10ps
module cbs_top_properties (
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic signed [15:0] torque_act,
    input wire logic signed [15:0] speed_act,
    input wire logic signed [15:0] cabin_ain_one_raw,
    input wire logic signed [15:0] cabin_ain_two_raw,
    input wire logic signed [15:0] cabin_torque_out,
    input wire logic signed [15:0] cabin_speed_out,
    input wire logic signed [15:0] cabin_speed_ref_one,
    input wire logic signed [15:0] cabin_speed_ref_two,
    input wire logic               brake_lift,
    input wire logic               dc_forcing,
    input wire logic               hold_zero,
    input wire logic               drive_enable,
    input wire logic               open_fault,
    input wire logic               dangerous_fault,
    input wire logic               fault_relay_open
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_open;
        !brake_lift ##1 brake_lift;
    endsequence

    sequence s_close;
        brake_lift ##1 !brake_lift;
    endsequence

    chk_lift_with_dc: assert property (s_open |-> dc_forcing)
        else $error("forcing output low when lift rose");
    chk_drop_to_hold: assert property (s_close |-> hold_zero || open_fault)
        else $error("no zero-speed hold after close order");
    chk_hold_regulated: assert property (hold_zero |-> drive_enable && !brake_lift)
        else $error("drive not regulating during hold");
    chk_timeout_stop: assert property ($rose(open_fault) |-> !brake_lift && !hold_zero && !drive_enable)
        else $error("motion not stopped on open timeout");
    chk_fault_blocks: assert property ((open_fault || dangerous_fault) && !brake_lift |=> !brake_lift)
        else $error("brake reopened while faulted");
    chk_danger_sticky: assert property (dangerous_fault |=> dangerous_fault && !drive_enable)
        else $error("dangerous fault not latched");
    chk_relay_tracks: assert property (fault_relay_open == dangerous_fault)
        else $error("fault relay differs from dangerous fault");
    chk_danger_kind: assert property ($rose(dangerous_fault) |-> $stable(open_fault))
        else $error("dangerous fault also set the open fault");
    chk_torque_scale: assert property ($past(nrst) && $past(torque_act) inside {[-4000:4000]} |->
        cabin_torque_out == $past(torque_act) * 32767 / 4000) else $error("torque output scaling wrong");
    chk_speed_scale: assert property ($past(nrst) |->
        cabin_speed_out == $past(speed_act) * 32767 / 2000) else $error("speed output scaling wrong");
    chk_ref_scale: assert property ($past(nrst) |->
        cabin_speed_ref_one == $past(cabin_ain_one_raw) * 1000 / 32767) else $error("reference scaling wrong");
    chk_ref_two_scale: assert property ($past(nrst) |->
        cabin_speed_ref_two == $past(cabin_ain_two_raw) * 1000 / 32767)
        else $error("second reference scaling wrong");
endmodule

bind cbs_top cbs_top_properties cbs_top_properties_i (.clk, .nrst, .torque_act, .speed_act, .cabin_ain_one_raw,
    .cabin_ain_two_raw, .cabin_torque_out, .cabin_speed_out, .cabin_speed_ref_one, .cabin_speed_ref_two,
    .brake_lift, .dc_forcing, .hold_zero, .drive_enable, .open_fault, .dangerous_fault, .fault_relay_open);

// *** cbs_brake_model.sv ***
// Behavioural brake contactor with open limit switch.
`timescale 1ns/10ps
module cbs_brake_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        brake_lift,
    input  wire logic [15:0] ack_dly,
    input  wire logic        stuck,
    input  wire logic        never,
    output logic             brake_ack
);
    logic [15:0] cnt;
    logic        tgt;

    // The switch follows the lift order after ack_dly + 1 cycles; a jammed brake keeps it set, a dead one never sets it.
    assign tgt = !never && (brake_lift || (stuck && brake_ack));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt       <= 16'h0000;
            brake_ack <= 1'b0;
        end else if (tgt == brake_ack) begin
            cnt <= 16'h0000;
        end else if (cnt >= ack_dly) begin
            cnt       <= 16'h0000;
            brake_ack <= tgt;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule

// *** tb.sv ***
// Self-checking bench of the brake sequencer.
`timescale 1ns/10ps
module tb;
    import cbs_pkg::*;
    logic               clk = 0, nrst = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic               dir_a = 0, dir_b = 0, stuck = 0, never = 0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0, prdata;
    logic [15:0]        ack_dly = 16'h001E;
    logic signed [15:0] speed_ref = 0, speed_act = 0, torque_act = 0, cabin_ain_one_raw = 0, cabin_ain_two_raw = 0;
    logic signed [15:0] cabin_speed_ref_one, cabin_speed_ref_two, cabin_torque_out, cabin_speed_out;
    logic               pready, pslverr, brake_lift, dc_forcing, hold_zero, drive_enable, integral_enable;
    logic               open_fault, dangerous_fault, fault_relay_open, brake_ack;
    logic [5:0]         st;
    logic [32:0]        q[$];
    int                 n_errors = 0, cmp_count = 0, seed = 67, n, m;
    localparam logic [31:0] RV [7] = '{32'h3, 32'h0, 32'h2, 32'h3E8, 32'h64, 32'h5DC, 32'h3E8};
    localparam logic [7:0]  SRCS [4] = '{8'h00, 8'h01, 8'h0A, 8'h0B};

    assign st = {brake_ack, dangerous_fault, open_fault, hold_zero, dc_forcing, brake_lift};
    always #4 clk = ~clk;
    always @(posedge clk) begin
        torque_act <= 16'($random(seed) % 5000);
        cabin_ain_one_raw <= 16'($random(seed));
        cabin_ain_two_raw <= 16'($random(seed));
    end

    cbs_top #(.TICK_CYC(10)) cbs_top_i (.clk, .nrst, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .dir_a, .dir_b, .brake_ack, .speed_ref, .speed_act, .torque_act, .cabin_ain_one_raw,
        .cabin_ain_two_raw, .cabin_speed_ref_one, .cabin_speed_ref_two, .cabin_torque_out, .cabin_speed_out,
        .brake_lift, .dc_forcing, .hold_zero, .drive_enable, .integral_enable, .open_fault, .dangerous_fault,
        .fault_relay_open);
    cbs_brake_model cbs_brake_model_i (.clk, .nrst, .brake_lift, .ack_dly, .stuck, .never, .brake_ack);

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task give_up;
        chk(1'b0, 1'b1);
        give_verdict;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (k > 20) give_up;
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read data and the error flag are taken at the edge that completes the access.
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, q.size() > 0 ? q.pop_front() : 33'h1FFFFFFFF);
    end

    task waitv(input int b, input logic v, input int lim, output int c);
        c = 0;
        while (st[b] !== v) begin
            c++;
            if (c > lim) give_up;
            @(negedge clk);
        end
        @(posedge clk);
    endtask

    task run_cycle(input logic [7:0] src);
        apb(1'b1, A_ACKSRC, {24'h0, src}, '0);
        repeat (2) @(negedge clk);
        chk(integral_enable, src >= 8'h0A);
        @(posedge clk);
        dir_a <= 1'b1;
        waitv(0, 1'b1, 20, n);
        chk(dc_forcing, 1'b1);
        waitv(1, 1'b0, 400, n);
        chk(src[0] ? (n >= 195 && n <= 212) : (n < 60), 1'b1);
        speed_act <= 16'($random(seed) % 20);
        dir_a <= 1'b0;
        waitv(0, 1'b0, 8, n);
        waitv(2, 1'b0, 100, n);
        chk(n >= 45 && n <= 56, 1'b1);
        speed_act <= '0;
        waitv(5, 1'b0, 100, n);
        $display("ack source %0d test done", src);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++) apb(1'b0, 8'(i * 4), '0, {1'b0, RV[i]});
        apb(1'b1, A_STATUS, 32'hFFFF, '0);
        apb(1'b0, A_STATUS, '0, 33'h080);
        apb(1'b0, 8'h24, '0, 33'h100000000);
        apb(1'b1, A_HOLD, 32'h5, '0);
        apb(1'b1, A_FORCE, 32'h14, '0);
        apb(1'b1, A_ACKTO, 32'h1E, '0);
        apb(1'b1, A_REFDLY, 32'hF, '0);
        apb(1'b0, A_FORCE, '0, 33'h014);
        $display("register test done");
        foreach (SRCS[i]) run_cycle(SRCS[i]);
        apb(1'b1, A_ACKSRC, '0, '0);
        speed_act <= 16'sh01F4;
        speed_ref <= 16'sh012C;
        dir_b <= 1'b1;
        waitv(5, 1'b1, 100, n);
        dir_b <= 1'b0;
        speed_ref <= '0;
        waitv(0, 1'b0, 300, n);
        chk(n >= 145 && n <= 170, 1'b1);
        waitv(2, 1'b0, 100, n);
        speed_act <= '0;
        waitv(5, 1'b0, 100, n);
        $display("reference delay test done");
        never <= 1'b1;
        dir_a <= 1'b1;
        waitv(0, 1'b1, 20, n);
        waitv(3, 1'b1, 400, n);
        chk(n >= 290 && n <= 312, 1'b1);
        chk(st[2:0], 3'b000);
        never <= 1'b0;
        dir_a <= 1'b0;
        apb(1'b1, A_FCLR, 32'h1, '0);
        @(negedge clk);
        chk(open_fault, 1'b0);
        @(posedge clk);
        $display("open timeout test done");
        apb(1'b1, A_CTRL, 32'h5, '0);
        stuck <= 1'b1;
        dir_a <= 1'b1;
        waitv(5, 1'b1, 100, n);
        dir_a <= 1'b0;
        waitv(0, 1'b0, 8, n);
        waitv(1, 1'b0, 300, n);
        chk(n >= 195 && n <= 212, 1'b1);
        waitv(4, 1'b1, 6000, m);
        chk(n + m >= 4985 && n + m <= 5030, 1'b1);
        chk({open_fault, fault_relay_open}, 2'b01);
        dir_a <= 1'b1;
        repeat (30) @(posedge clk);
        chk(brake_lift, 1'b0);
        nrst <= 1'b0;
        dir_a <= 1'b0;
        stuck <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk(dangerous_fault, 1'b0);
        $display("closing supervision test done");
        give_verdict;
    end
endmodule
